/* File: shared/fucs_pkg.sv */
// types shared by the flash sequencer files
package fucs_pkg;

    // gray codes along locked, first, second, unlocked, program
    typedef enum logic [2:0] {
        FUCS_LOCKED   = 3'b000,
        FUCS_FIRST    = 3'b001,
        FUCS_SECOND   = 3'b011,
        FUCS_UNLOCKED = 3'b010,
        FUCS_PROGRAM  = 3'b110,
        FUCS_PAGE_ERS = 3'b111,
        FUCS_MASS_ERS = 3'b101,
        FUCS_BPROT    = 3'b100
    } fucs_seq_e;

    typedef enum logic [1:0] {
        FUCS_OL_BYTE0 = 2'b00,
        FUCS_OL_BYTE1 = 2'b01,
        FUCS_OL_WAIT  = 2'b11,
        FUCS_OL_DONE  = 2'b10
    } fucs_load_e;

endpackage

/* File: shared/fucs_regs.svh */
// register offsets, command codes and reset values of the flash sequencer
// Function
// - command 73h is the first unlock step and is recorded as such
// - command 8Ch is the second unlock step and is recorded as such
// - 95h written third, after both unlock codes, starts page erase
// - 63h written third, after both unlock codes, starts mass erase
// - command 5Eh selects block protect register access
// - one address: writes reach the command port, reads the status
// - status readable any time without disturbing a running operation
// - status 000 locked, 001 first, 010 second, 011 unlocked
// - status 100 protect, 101 program, 110 page erase, 111 mass erase
// - status bits 7 to 3 read zero; software writes them zero
// - every reset and stop recovery loads option bits from program memory
// - new option bits take effect only after the next reload
// - option loading completes before system reset is released
// - option configuration registers are not reachable by software
// - user option bits come from the first two program memory bytes
`ifndef FUCS_REGS_SVH
`define FUCS_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define FUCS_ADDR_CMD      12'h0ff8
`define FUCS_CMD_RESET     8'h00
`define FUCS_STAT_RESET    8'h00
`define FUCS_STAT_LSB      0
`define FUCS_STAT_MSB      2

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define FUCS_CMD_UNLOCK1   8'h73
`define FUCS_CMD_UNLOCK2   8'h8c
`define FUCS_CMD_PAGE_ERS  8'h95
`define FUCS_CMD_MASS_ERS  8'h63
`define FUCS_CMD_BPROT     8'h5e

// ----------------------------------------------------------------
// status codes
// ----------------------------------------------------------------
`define FUCS_ST_LOCKED     3'h0
`define FUCS_ST_FIRST      3'h1
`define FUCS_ST_SECOND     3'h2
`define FUCS_ST_UNLOCKED   3'h3
`define FUCS_ST_BPROT      3'h4
`define FUCS_ST_PROGRAM    3'h5
`define FUCS_ST_PAGE_ERS   3'h6
`define FUCS_ST_MASS_ERS   3'h7

// ----------------------------------------------------------------
// option bits
// ----------------------------------------------------------------
`define FUCS_OPT_ADDR0     16'h0000
`define FUCS_OPT_ADDR1     16'h0001
`define FUCS_OPT_RESET     8'h00

`endif

/* File: testbench/fucs_seq_assertions.sv */
// port assertions for the flash sequencer
`timescale 1ns/1ns
`default_nettype none
`include "fucs_regs.svh"

module fucs_seq_checker (
    // clock and reset
    input wire logic        i_clock, i_rstn, i_stop_recovery,
    // register port
    input wire logic [11:0] i_reg_addr,
    input wire logic        i_reg_wr, i_reg_rd,
    input wire logic [7:0]  i_reg_wdata, o_reg_rdata,
    // flash array side
    input wire logic        i_prog_req, i_op_done, o_prog_start,
    input wire logic        o_page_erase_start, o_mass_erase_start,
    input wire logic        o_bprot_access, o_unlocked,
    // option loading
    input wire logic [15:0] o_pm_addr,
    input wire logic        o_pm_rd, o_sys_rstn,
    input wire logic [7:0]  i_pm_rdata, o_opt_cfg0, o_opt_cfg1
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    wire cmd_wr;
    wire any_start;
    // writes during option loading are refused, so leave them out
    assign cmd_wr = i_reg_wr && i_reg_addr == `FUCS_ADDR_CMD && o_sys_rstn;
    assign any_start = o_prog_start || o_page_erase_start
                       || o_mass_erase_start;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    a_read_idle: assert property (
        !(i_reg_rd && i_reg_addr == `FUCS_ADDR_CMD) |=> o_reg_rdata == 8'h00
    ) else $error("read data not zero outside a status read");
    a_rsvd_zero: assert property (
        i_reg_rd |=> o_reg_rdata[7:3] == 5'h00
    ) else $error("reserved status bits not zero");
    a_page_start: assert property (
        o_unlocked && cmd_wr && i_reg_wdata == `FUCS_CMD_PAGE_ERS
        && !i_stop_recovery |=> o_page_erase_start && !o_unlocked
    ) else $error("page erase did not start");
    a_mass_start: assert property (
        o_unlocked && cmd_wr && i_reg_wdata == `FUCS_CMD_MASS_ERS
        && !i_stop_recovery |=> o_mass_erase_start && !o_unlocked
    ) else $error("mass erase did not start");
    a_prog_start: assert property (
        o_unlocked && i_prog_req && !i_reg_wr && !i_stop_recovery
        |=> o_prog_start
    ) else $error("program did not start");
    a_start_pulse: assert property (
        any_start |=> !any_start
    ) else $error("start pulse longer than one cycle");
    a_start_cause: assert property (
        !o_unlocked |=> !any_start
    ) else $error("operation started while not unlocked");
    a_bprot_exit: assert property (
        o_bprot_access && cmd_wr && i_reg_wdata != `FUCS_CMD_BPROT
        |=> !o_bprot_access
    ) else $error("protect access kept after another command");
    a_stop_lock: assert property (
        i_stop_recovery |=> !o_unlocked && !o_bprot_access
    ) else $error("stop recovery did not relock");
    a_boot_load: assert property (
        $rose(i_rstn) |-> !o_sys_rstn [*3] ##1 o_sys_rstn
    ) else $error("system reset release time wrong after reset");
    a_stop_load: assert property (
        i_stop_recovery && o_sys_rstn |=> !o_sys_rstn [*3] ##1 o_sys_rstn
    ) else $error("option reload after stop recovery wrong");
    a_pm_idle: assert property (
        o_sys_rstn |-> !o_pm_rd
    ) else $error("program memory read while running");
    a_opt_hold: assert property (
        o_sys_rstn && $past(o_sys_rstn)
        |-> $stable(o_opt_cfg0) && $stable(o_opt_cfg1)
    ) else $error("option configuration changed while running");
endmodule

bind fucs_sequencer fucs_seq_checker u_chk (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_stop_recovery(i_stop_recovery),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_prog_req(i_prog_req), .i_op_done(i_op_done),
    .o_prog_start(o_prog_start), .o_page_erase_start(o_page_erase_start),
    .o_mass_erase_start(o_mass_erase_start),
    .o_bprot_access(o_bprot_access), .o_unlocked(o_unlocked),
    .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd), .o_sys_rstn(o_sys_rstn),
    .i_pm_rdata(i_pm_rdata), .o_opt_cfg0(o_opt_cfg0),
    .o_opt_cfg1(o_opt_cfg1)
);
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the flash sequencer
`timescale 1ns/1ns
`default_nettype none
`include "fucs_regs.svh"

module testbench;
    // ------------------------------------------------------------
    // signals and bench state
    // ------------------------------------------------------------
    logic        i_clock, i_rstn, i_stop_recovery, i_reg_wr, i_reg_rd;
    logic        i_prog_req, i_op_done;
    logic [11:0] i_reg_addr;
    logic [7:0]  i_reg_wdata, i_pm_rdata, o_reg_rdata;
    logic [7:0]  o_opt_cfg0, o_opt_cfg1, snap_rd, snap_fl;
    logic [15:0] o_pm_addr, old_opt;
    logic        o_prog_start, o_page_erase_start, o_mass_erase_start;
    logic        o_bprot_access, o_unlocked, o_pm_rd, o_sys_rstn;
    logic [7:0]  opt_mem [2];
    logic [31:0] seed;
    logic [1:0]  kind;
    int          errors, n_tests, cycles, st;
    // kind, address, data: reset read, program, erases, protect, misorder
    localparam logic [21:0] DIR [19] = '{
        {2'h0, 12'h0ff0, 8'h00}, {2'h0, 12'h0ff8, 8'h73},
        {2'h0, 12'h0ff8, 8'h8c}, {2'h1, 12'h0ff8, 8'h00},
        {2'h2, 12'h0ff8, 8'h00}, {2'h0, 12'h0ff8, 8'h63},
        {2'h0, 12'h0ff8, 8'h95}, {2'h2, 12'h0ff8, 8'h00},
        {2'h0, 12'h0ff8, 8'h73}, {2'h0, 12'h0ff8, 8'h8c},
        {2'h0, 12'h0ff8, 8'h95}, {2'h2, 12'h0ff8, 8'h00},
        {2'h0, 12'h0ff8, 8'h5e}, {2'h0, 12'h0ff8, 8'h5e},
        {2'h0, 12'h0ff8, 8'h73}, {2'h0, 12'h0ff8, 8'h73},
        {2'h0, 12'h0ff8, 8'h95}, {2'h1, 12'h0ff8, 8'h00},
        {2'h0, 12'h0ff7, 8'h73}};
    localparam logic [7:0] CODES [8] = '{8'h73, 8'h8c, 8'h95, 8'h63,
                                         8'h5e, 8'h73, 8'h8c, 8'h00};

    fucs_sequencer uut (
        .i_clock(i_clock), .i_rstn(i_rstn),
        .i_stop_recovery(i_stop_recovery), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_prog_req(i_prog_req), .i_op_done(i_op_done),
        .o_prog_start(o_prog_start),
        .o_page_erase_start(o_page_erase_start),
        .o_mass_erase_start(o_mass_erase_start),
        .o_bprot_access(o_bprot_access), .o_unlocked(o_unlocked),
        .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd), .i_pm_rdata(i_pm_rdata),
        .o_opt_cfg0(o_opt_cfg0), .o_opt_cfg1(o_opt_cfg1),
        .o_sys_rstn(o_sys_rstn)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // status after a command write; busy states ignore commands
    function automatic int model_wr(input int s, input logic [7:0] c);
        if (s >= 5) return s;
        if (s == 0) return c == 8'h73 ? 1 : (c == 8'h5e ? 4 : 0);
        if (s == 1) return c == 8'h8c ? 2 : 0;
        if (s == 4) return c == 8'h5e ? 4 : 0;
        return c == 8'h95 ? 6 : (c == 8'h63 ? 7 : 0);
    endfunction

    task automatic check(input string what, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // drives one cycle and snapshots the effect of the previous one
    task automatic put(input logic wr, rd, pr, dn, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge i_clock);
        i_reg_wr    <= wr;
        i_reg_rd    <= rd;
        i_prog_req  <= pr;
        i_op_done   <= dn;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        #1;
        snap_rd = o_reg_rdata;
        snap_fl = {3'h0, o_unlocked, o_bprot_access, o_prog_start,
                   o_page_erase_start, o_mass_erase_start};
    endtask

    // one request, then a status read, both against the model
    task automatic step(input logic [1:0] k, input logic [11:0] a,
                        input logic [7:0] d);
        int nx;
        nx = st;
        if (k == 2'h1 && (st == 2 || st == 3)) nx = 5;
        if (k == 2'h2) nx = st == 5 ? 3 : (st >= 6 ? 0 : st);
        if (k == 2'h0 && a == `FUCS_ADDR_CMD) nx = model_wr(st, d);
        put(k == 2'h0, 1'b0, k == 2'h1, k == 2'h2, a, d);
        put(1'b0, 1'b1, 1'b0, 1'b0, `FUCS_ADDR_CMD, 8'h00);
        check("flags", snap_fl, {3'h0, nx == 2 || nx == 3, nx == 4,
              nx == 5 && st != 5, nx == 6 && st != 6,
              nx == 7 && st != 7});
        put(1'b0, 1'b0, 1'b0, 1'b0, `FUCS_ADDR_CMD, 8'h00);
        check("status", snap_rd, {5'h00, nx[2:0]});
        st = nx;
    endtask

    task automatic wait_run;
        for (int i = 0; i < 20 && o_sys_rstn !== 1'b1; i++) begin
            @(posedge i_clock);
        end
        #1;
    endtask

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // the flash answers one cycle after the address
    always @(posedge i_clock) begin
        i_pm_rdata <= opt_mem[o_pm_addr[0]];
        cycles     <= cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            report_and_stop;
        end
    end

    initial begin
        {i_rstn, i_stop_recovery, i_reg_wr, i_reg_rd} = 4'h0;
        {i_prog_req, i_op_done, i_reg_addr, i_reg_wdata} = 22'h00_0000;
        {errors, n_tests, cycles, st} = 128'h0;
        seed = 32'h0001_75b0;
        opt_mem = '{seed[7:0], seed[15:8]};
        i_pm_rdata = 8'h00;
        repeat (3) @(posedge i_clock);
        i_rstn <= 1'b1;
        wait_run();
        check("opt0", o_opt_cfg0, opt_mem[0]);
        check("opt1", o_opt_cfg1, opt_mem[1]);
        // ------------------------------------------------------------
        // directed sequences, then back to back unlock and erase
        // ------------------------------------------------------------
        foreach (DIR[i]) step(DIR[i][21:20], DIR[i][19:8], DIR[i][7:0]);
        put(1'b1, 1'b0, 1'b0, 1'b0, `FUCS_ADDR_CMD, 8'h73);
        put(1'b1, 1'b0, 1'b0, 1'b0, `FUCS_ADDR_CMD, 8'h8c);
        put(1'b1, 1'b0, 1'b0, 1'b0, `FUCS_ADDR_CMD, 8'h95);
        put(1'b0, 1'b1, 1'b0, 1'b0, `FUCS_ADDR_CMD, 8'h00);
        check("flags", snap_fl, 8'h02);
        put(1'b0, 1'b0, 1'b0, 1'b0, `FUCS_ADDR_CMD, 8'h00);
        check("status", snap_rd, 8'h06);
        st = 6;
        step(2'h2, `FUCS_ADDR_CMD, 8'h00);
        $display("directed test done");
        // ------------------------------------------------------------
        // random commands, addresses and array events
        // ------------------------------------------------------------
        repeat (60) begin
            seed = lfsr(seed);
            kind = seed[9:8] == 2'h3 ? 2'h0 : seed[9:8];
            step(kind, seed[15:13] == 3'h0 ? {9'h1fe, seed[18:16]}
                 : `FUCS_ADDR_CMD, seed[2:0] == 3'h7 ? seed[31:24]
                 : CODES[seed[2:0]]);
        end
        $display("random test done");
        // ------------------------------------------------------------
        // option reload on stop recovery, writes refused meanwhile
        // ------------------------------------------------------------
        old_opt = {o_opt_cfg1, o_opt_cfg0};
        opt_mem = '{seed[23:16], seed[31:24]};
        // finish any running operation, then relock through the model
        step(2'h2, `FUCS_ADDR_CMD, 8'h00);
        step(2'h0, `FUCS_ADDR_CMD, 8'h00);
        step(2'h0, `FUCS_ADDR_CMD, 8'h73);
        step(2'h0, `FUCS_ADDR_CMD, 8'h8c);
        check("opt hold", o_opt_cfg0, old_opt[7:0]);
        check("opt hold", o_opt_cfg1, old_opt[15:8]);
        @(posedge i_clock);
        i_stop_recovery <= 1'b1;
        @(posedge i_clock);
        i_stop_recovery <= 1'b0;
        @(posedge i_clock);
        i_reg_wr <= 1'b1;
        i_reg_wdata <= 8'h73;
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
        wait_run();
        st = 0;
        step(2'h0, 12'h0ff0, 8'h00);
        check("opt0", o_opt_cfg0, opt_mem[0]);
        check("opt1", o_opt_cfg1, opt_mem[1]);
        $display("option test done");
        report_and_stop;
    end
endmodule
`default_nettype wire

/* File: verilog/fucs_option_loader.sv */
// option bit loader run at every reset and stop-mode recovery
`timescale 1ns/1ns
`default_nettype none
`include "fucs_regs.svh"

module fucs_option_loader (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic        i_stop_recovery,
    // program memory read port, data one cycle after address
    output logic [15:0]      o_pm_addr,
    output logic             o_pm_rd,
    input  wire logic [7:0]  i_pm_rdata,
    // hidden option configuration, not in the register file
    output logic [7:0]       o_opt_cfg0,
    output logic [7:0]       o_opt_cfg1,
    output logic             o_load_done
);

    fucs_pkg::fucs_load_e st_q;
    fucs_pkg::fucs_load_e st_d;
    logic [7:0]           cfg0_q;
    logic [7:0]           cfg1_q;
    logic                 take0;
    logic                 take1;

    // ----------------------------------------------------------------
    // load sequence
    // ----------------------------------------------------------------
    // byte 0 is requested in the first cycle after release and
    // captured while byte 1 is requested
    assign take0 = (st_q == fucs_pkg::FUCS_OL_BYTE1);
    assign take1 = (st_q == fucs_pkg::FUCS_OL_WAIT);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            fucs_pkg::FUCS_OL_BYTE0: st_d = fucs_pkg::FUCS_OL_BYTE1;
            fucs_pkg::FUCS_OL_BYTE1: st_d = fucs_pkg::FUCS_OL_WAIT;
            fucs_pkg::FUCS_OL_WAIT:  st_d = fucs_pkg::FUCS_OL_DONE;
            fucs_pkg::FUCS_OL_DONE: begin
                if (i_stop_recovery) begin
                    st_d = fucs_pkg::FUCS_OL_BYTE0;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= fucs_pkg::FUCS_OL_BYTE0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // written only here, so fresh flash contents wait for a reload
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg0_q <= `FUCS_OPT_RESET;
            cfg1_q <= `FUCS_OPT_RESET;
        end else begin
            if (take0) begin
                cfg0_q <= i_pm_rdata;
            end
            if (take1) begin
                cfg1_q <= i_pm_rdata;
            end
        end
    end

    assign o_pm_rd     = (st_q == fucs_pkg::FUCS_OL_BYTE0) || take0;
    assign o_pm_addr   = take0 ? `FUCS_OPT_ADDR1 : `FUCS_OPT_ADDR0;
    assign o_opt_cfg0  = cfg0_q;
    assign o_opt_cfg1  = cfg1_q;
    assign o_load_done = (st_q == fucs_pkg::FUCS_OL_DONE);

endmodule
`default_nettype wire

/* File: verilog/fucs_sequencer.sv */
// flash command port, unlock sequencer and status register
`timescale 1ns/1ns
`default_nettype none
`include "fucs_regs.svh"

module fucs_sequencer (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic        i_stop_recovery,
    // register file port
    input  wire logic [11:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_wdata,
    output logic [7:0]       o_reg_rdata,
    // flash array side
    input  wire logic        i_prog_req,
    input  wire logic        i_op_done,
    output logic             o_prog_start,
    output logic             o_page_erase_start,
    output logic             o_mass_erase_start,
    output logic             o_bprot_access,
    output logic             o_unlocked,
    // program memory port for option loading
    output logic [15:0]      o_pm_addr,
    output logic             o_pm_rd,
    input  wire logic [7:0]  i_pm_rdata,
    // option configuration and system reset release
    output logic [7:0]       o_opt_cfg0,
    output logic [7:0]       o_opt_cfg1,
    output logic             o_sys_rstn
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    fucs_pkg::fucs_seq_e st_q;
    fucs_pkg::fucs_seq_e st_d;
    logic [7:0]          rdata_q;
    logic                prog_q;
    logic                page_q;
    logic                mass_q;
    logic                load_done;
    logic                hit;
    logic                cmd_wr;
    logic                stat_rd;
    logic [2:0]          stat_code;
    logic                is_unlock1;
    logic                is_unlock2;
    logic                is_page;
    logic                is_mass;
    logic                is_bprot;
    logic                armed;
    logic                busy;
    logic                go_page;
    logic                go_mass;
    logic                go_prog;

    // ----------------------------------------------------------------
    // option loader
    // ----------------------------------------------------------------
    fucs_option_loader u_loader (
        .i_clock         (i_clock),
        .i_rstn          (i_rstn),
        .i_stop_recovery (i_stop_recovery),
        .o_pm_addr       (o_pm_addr),
        .o_pm_rd         (o_pm_rd),
        .i_pm_rdata      (i_pm_rdata),
        .o_opt_cfg0      (o_opt_cfg0),
        .o_opt_cfg1      (o_opt_cfg1),
        .o_load_done     (load_done)
    );

    // the cpu stays in reset until both option bytes are in place
    assign o_sys_rstn = load_done;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // one shared address: direction alone picks port or status
    assign hit     = (i_reg_addr == `FUCS_ADDR_CMD);
    assign cmd_wr  = hit && i_reg_wr && load_done;
    assign stat_rd = hit && i_reg_rd;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    assign is_unlock1 = (i_reg_wdata == `FUCS_CMD_UNLOCK1);
    assign is_unlock2 = (i_reg_wdata == `FUCS_CMD_UNLOCK2);
    assign is_page    = (i_reg_wdata == `FUCS_CMD_PAGE_ERS);
    assign is_mass    = (i_reg_wdata == `FUCS_CMD_MASS_ERS);
    assign is_bprot   = (i_reg_wdata == `FUCS_CMD_BPROT);

    assign armed = (st_q == fucs_pkg::FUCS_SECOND)
                || (st_q == fucs_pkg::FUCS_UNLOCKED);
    assign busy  = (st_q == fucs_pkg::FUCS_PROGRAM)
                || (st_q == fucs_pkg::FUCS_PAGE_ERS)
                || (st_q == fucs_pkg::FUCS_MASS_ERS);

    assign go_page = cmd_wr && armed && is_page;
    assign go_mass = cmd_wr && armed && is_mass;
    // a command write in the same cycle wins over a program request
    assign go_prog = !cmd_wr && armed && i_prog_req;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // command writes during a running operation are ignored so that
    // an erase cannot be cut short from software
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            fucs_pkg::FUCS_LOCKED: begin
                if (cmd_wr && is_unlock1) begin
                    st_d = fucs_pkg::FUCS_FIRST;
                end else if (cmd_wr && is_bprot) begin
                    st_d = fucs_pkg::FUCS_BPROT;
                end
            end
            fucs_pkg::FUCS_FIRST: begin
                if (cmd_wr && is_unlock2) begin
                    st_d = fucs_pkg::FUCS_SECOND;
                end else if (cmd_wr) begin
                    st_d = fucs_pkg::FUCS_LOCKED;
                end
            end
            fucs_pkg::FUCS_SECOND,
            fucs_pkg::FUCS_UNLOCKED: begin
                if (go_page) begin
                    st_d = fucs_pkg::FUCS_PAGE_ERS;
                end else if (go_mass) begin
                    st_d = fucs_pkg::FUCS_MASS_ERS;
                end else if (cmd_wr) begin
                    st_d = fucs_pkg::FUCS_LOCKED;
                end else if (go_prog) begin
                    st_d = fucs_pkg::FUCS_PROGRAM;
                end
            end
            fucs_pkg::FUCS_BPROT: begin
                if (cmd_wr && !is_bprot) begin
                    st_d = fucs_pkg::FUCS_LOCKED;
                end
            end
            fucs_pkg::FUCS_PROGRAM: begin
                // stays open for the next byte of the same page
                if (i_op_done) begin
                    st_d = fucs_pkg::FUCS_UNLOCKED;
                end
            end
            fucs_pkg::FUCS_PAGE_ERS,
            fucs_pkg::FUCS_MASS_ERS: begin
                if (i_op_done) begin
                    st_d = fucs_pkg::FUCS_LOCKED;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= fucs_pkg::FUCS_LOCKED;
        end else if (i_stop_recovery) begin
            st_q <= fucs_pkg::FUCS_LOCKED;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // start pulses
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            prog_q <= 1'b0;
            page_q <= 1'b0;
            mass_q <= 1'b0;
        end else begin
            prog_q <= go_prog && !i_stop_recovery;
            page_q <= go_page && !i_stop_recovery;
            mass_q <= go_mass && !i_stop_recovery;
        end
    end

    assign o_prog_start       = prog_q;
    assign o_page_erase_start = page_q;
    assign o_mass_erase_start = mass_q;
    assign o_bprot_access     = (st_q == fucs_pkg::FUCS_BPROT);
    assign o_unlocked         = armed;

    // ----------------------------------------------------------------
    // status register
    // ----------------------------------------------------------------
    always_comb begin
        stat_code = `FUCS_ST_LOCKED;
        unique case (st_q)
            fucs_pkg::FUCS_LOCKED:   stat_code = `FUCS_ST_LOCKED;
            fucs_pkg::FUCS_FIRST:    stat_code = `FUCS_ST_FIRST;
            fucs_pkg::FUCS_SECOND:   stat_code = `FUCS_ST_SECOND;
            fucs_pkg::FUCS_UNLOCKED: stat_code = `FUCS_ST_UNLOCKED;
            fucs_pkg::FUCS_BPROT:    stat_code = `FUCS_ST_BPROT;
            fucs_pkg::FUCS_PROGRAM:  stat_code = `FUCS_ST_PROGRAM;
            fucs_pkg::FUCS_PAGE_ERS: stat_code = `FUCS_ST_PAGE_ERS;
            fucs_pkg::FUCS_MASS_ERS: stat_code = `FUCS_ST_MASS_ERS;
        endcase
    end

    // reads only sample state; nothing in the sequencer looks at them,
    // and the hidden option bytes never appear on this path
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= `FUCS_STAT_RESET;
        end else if (stat_rd) begin
            rdata_q <= {5'h00, stat_code};
        end else begin
            rdata_q <= `FUCS_STAT_RESET;
        end
    end

    assign o_reg_rdata = rdata_q;

endmodule
`default_nettype wire
